// >>> bench/ccl_comparator_model.sv
// behavioural comparator, input mux and both reference generators
// assumes channel levels in mV come from the bench; released inputs read as 0 mV
`timescale 1ns/1ps
module ccl_comparator_model
#(
   parameter int SUPPLY_MV = 3000,
   parameter int TEMP_MV = 300
)
(
   input wire ccl_pkg::ccl_analog_t analogCtrl,
   input var int chanMv [8],
   output logic cmpRaw
);
   int pv;
   int nv;
   int r1;
   always_comb
   begin
      pv = 0;
      nv = 0;
      for (int i = 0; i < 8; i++)
      begin
         if (analogCtrl.posChannelOn[i]) pv = chanMv[i];
         if (analogCtrl.negChannelOn[i]) nv = chanMv[i];
      end
      // shorted inputs sit at one level, so the result is low unless a reference is then switched onto an input
      if (analogCtrl.inputShort) nv = pv;
      if (analogCtrl.inputSwap) {pv, nv} = {nv, pv};
      r1 = TEMP_MV;
      if (analogCtrl.refOneSelect == ccl_pkg::REF1_HALF) r1 = SUPPLY_MV / 2;
      if (analogCtrl.refOneSelect == ccl_pkg::REF1_QUARTER) r1 = SUPPLY_MV / 4;
      if (analogCtrl.refOneOn && analogCtrl.refOneToNeg) nv = r1;
      if (analogCtrl.refOneOn && !analogCtrl.refOneToNeg) pv = r1;
      if (analogCtrl.refTwoOn && analogCtrl.refTwoToNeg) nv = analogCtrl.refTwoLevel * 625 / 10;
      if (analogCtrl.refTwoOn && !analogCtrl.refTwoToNeg) pv = analogCtrl.refTwoLevel * 625 / 10;
      cmpRaw = analogCtrl.unitEnable && (pv > nv);
   end
endmodule : ccl_comparator_model

// >>> bench/tb.sv
// self-checking bench for the comparator control logic
// assumes the AHB slave answers with zero wait states and hready tied to hreadyout
`timescale 1ns/1ps
module tb;
   typedef struct {int kind; string name; logic [31:0] exp;} ccl_note_t;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic commonModeOn = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic cmpRaw;
   logic comparatorOutput;
   logic cmpIrq;
   ccl_pkg::ccl_analog_t analogCtrl;
   int chanMv [8] = '{default: 0};
   int seed = 32'hb0b7;
   int miscompares = 0;
   int checked = 0;
   ccl_note_t q [$];
   event chkEv;
   ccl_comparator_control u_ccl_comparator_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cmpRaw(cmpRaw), .commonModeOn(commonModeOn),
      .analogCtrl(analogCtrl), .comparatorOutput(comparatorOutput), .cmpIrq(cmpIrq));
   ccl_comparator_model u_ccl_comparator_model (.analogCtrl(analogCtrl), .chanMv(chanMv),
      .cmpRaw(cmpRaw));
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end
   // ***************************************************
   // bus tasks and checking
   // ***************************************************
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
   endtask : ahb
   task automatic note(input int k, input string nm, input logic [31:0] e);
      q.push_back('{k, nm, e});
      -> chkEv;
   endtask : note
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      ahb(1'b0, a, 32'h0);
      note(0, nm, e);
      note(5, "hresp", 32'h0);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   function automatic ccl_pkg::ccl_analog_t ctl_exp(input logic [7:0] ic, input logic [7:0] oc,
      input logic [7:0] rc, input logic cm);
      ccl_pkg::ccl_analog_t e;
      e = '0;
      e.unitEnable = ic[7];
      e.posChannelOn = (ic[4:3] == 2'h0) ? 8'h00 : 8'h01 << (ic[4:3] - 2'h1);
      e.negChannelOn = (8'h01 << ic[2:0]) & 8'hfe;
      e.inputSwap = ic[5];
      e.inputShort = ic[6];
      e.refOneSelect = oc[2:1];
      e.refOneOn = oc[2:1] != 2'h0;
      e.refOneToNeg = oc[4] ^ ic[5];
      e.refTwoLevel = rc[3:0];
      e.refTwoOn = rc[3:0] != 4'h0 && cm;
      e.refTwoToNeg = rc[4] ^ ic[5];
      return e;
   endfunction : ctl_exp
   // outputs are looked at 1 ns after the note, once the edge has settled
   initial
   forever
   begin
      ccl_note_t n;
      logic [31:0] seen;
      @(chkEv);
      #1;
      while (q.size() > 0)
      begin
         n = q.pop_front();
         case (n.kind)
            0: seen = hrdata;
            1: seen = 32'(analogCtrl);
            2: seen = {31'h0, comparatorOutput};
            3: seen = {31'h0, cmpIrq};
            5: seen = {31'h0, hresp};
            default: seen = {22'h0, analogCtrl.posChannelOn, analogCtrl.refOneOn,
               analogCtrl.unitEnable};
         endcase
         check(n.name, seen, n.exp);
      end
   end
   initial
   begin
      repeat (50000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   // ***************************************************
   // scenarios
   // ***************************************************
   initial
   begin
      logic [31:0] r;
      logic [7:0] ic;
      logic [7:0] oc;
      logic [7:0] rc;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      note(1, "analogCtrl", 32'h0);
      rd(8'h00, {24'h0, ccl_pkg::RST_INPUT_CTRL}, "inputCtrl");
      rd(8'h04, {24'h0, ccl_pkg::RST_OUT_REF1_CTRL}, "outRefOneCtrl");
      rd(8'h08, {24'h0, ccl_pkg::RST_REF2_CTRL}, "refTwoCtrl");
      wr(8'h14, 32'hffffffff);
      rd(8'h14, 32'h0, "unmapped");
      $display("reset test done");
      for (int i = 0; i < 32; i++)
      begin
         r = $random(seed);
         ic = {1'b1, r[1:0], i[4:0]};
         oc = {1'b1, r[3:2], i[2], 1'b0, i[1:0], 1'b1};
         rc = {3'h7, r[4], i[3:0]};
         commonModeOn <= r[5];
         wr(8'h00, {r[31:8], ic});
         wr(8'h04, {24'h0, oc});
         wr(8'h08, {24'h0, rc});
         @(posedge clk_sys);
         note(1, "analogCtrl", 32'(ctl_exp(ic, oc, rc, r[5])));
         rd(8'h00, {24'h0, ic}, "inputCtrl");
         rd(8'h04, {24'h0, oc & 8'h7e}, "outRefOneCtrl");
         rd(8'h08, {24'h0, rc & 8'h1f}, "refTwoCtrl");
      end
      $display("mux and reference test done");
      chanMv[1] <= 1000;
      wr(8'h00, 32'h89);
      wr(8'h04, 32'h00);
      wr(8'h08, 32'h00);
      wr(8'h0c, 32'h3);
      repeat (8) @(posedge clk_sys);
      wr(8'h10, 32'h1);
      chanMv[0] <= 1500;
      repeat (2) @(posedge clk_sys);
      note(2, "cmpOut early", 32'h0);
      @(posedge clk_sys);
      note(2, "cmpOut", 32'h1);
      repeat (2) @(posedge clk_sys);
      note(3, "cmpIrq", 32'h1);
      rd(8'h10, 32'h3, "status");
      wr(8'h0c, 32'h1);
      @(posedge clk_sys);
      note(3, "cmpIrq masked", 32'h0);
      wr(8'h0c, 32'h3);
      @(posedge clk_sys);
      note(3, "cmpIrq again", 32'h1);
      wr(8'h10, 32'h1);
      @(posedge clk_sys);
      note(3, "cmpIrq cleared", 32'h0);
      wr(8'h04, 32'h40);
      repeat (4) @(posedge clk_sys);
      note(2, "cmpOut inverted", 32'h0);
      wr(8'h04, 32'h20);
      repeat (60) @(posedge clk_sys);
      note(2, "cmpOut filtered", 32'h1);
      chanMv[0] <= 0;
      repeat (20) @(posedge clk_sys);
      chanMv[0] <= 1500;
      repeat (60) @(posedge clk_sys);
      note(2, "cmpOut glitch", 32'h1);
      chanMv[0] <= 0;
      repeat (40) @(posedge clk_sys);
      note(2, "cmpOut in filter", 32'h1);
      repeat (20) @(posedge clk_sys);
      note(2, "cmpOut after filter", 32'h0);
      $display("output path test done");
      chanMv[0] <= 1000;
      wr(8'h04, 32'h1e);
      repeat (6) @(posedge clk_sys);
      note(1, "auto half", 32'(ctl_exp(8'h89, 8'h1e, 8'h00, commonModeOn)));
      chanMv[0] <= 1600;
      repeat (6) @(posedge clk_sys);
      note(1, "auto quarter", 32'(ctl_exp(8'h89, 8'h1c, 8'h00, commonModeOn)));
      note(2, "cmpOut auto", 32'h1);
      chanMv[0] <= 500;
      repeat (6) @(posedge clk_sys);
      note(1, "auto back", 32'(ctl_exp(8'h89, 8'h1e, 8'h00, commonModeOn)));
      chanMv[0] <= 1600;
      wr(8'h04, 32'h1a);
      repeat (6) @(posedge clk_sys);
      note(1, "auto off", 32'(ctl_exp(8'h89, 8'h1a, 8'h00, commonModeOn)));
      wr(8'h00, 32'h09);
      repeat (6) @(posedge clk_sys);
      note(4, "unit off", 32'h0);
      note(2, "cmpOut unit off", 32'h0);
      $display("auto switch and unit test done");
      #2;
      summarize();
   end
endmodule : tb

// >>> rtl/ccl_comparator_control.sv
// top of the comparator control logic: registers, analog switch control,
// output conditioning, auto switch of reference one and the interrupt flag
// assumes an AHB-Lite master and the analog comparator driving cmpRaw
`timescale 1ns/1ps
module ccl_comparator_control
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmpRaw,
   input wire logic commonModeOn,
   output ccl_pkg::ccl_analog_t analogCtrl,
   output logic comparatorOutput,
   output logic cmpIrq
);

   // ***************************************************
   // state
   // ***************************************************
   ccl_pkg::ccl_ctrl_t ctrl;
   logic irqEnable;
   logic globalIrqEnable;
   logic irqFlag;
   logic condPrev;
   logic autoHalf;
   logic syncRaw;
   logic filtRaw;
   logic condOut;
   logic condRise;
   logic autoActive;
   logic [1:0] effRefOne;
   logic [7:0] next_posOn;
   logic [7:0] next_negOn;
   logic phWrite;
   logic [7:0] phAddr;
   logic addrValid;
   logic flagClear;

   // one-hot channel decode, shared by both selectors
   function automatic logic [7:0] ccl_onehot(input logic [2:0] code);
      logic [7:0] v;
      v = '0;
      v[code] = 1'b1;
      return v;
   endfunction : ccl_onehot

   // ***************************************************
   // AHB-Lite slave
   // ***************************************************
   assign addrValid = hsel && hready && htrans[1];

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phWrite <= 1'b0;
         phAddr <= 8'h00;
      end
      else
      begin
         phWrite <= addrValid && hwrite;
         phAddr <= haddr;
      end
   end

   // zero wait states, always OKAY; unmapped reads return zero, writes ignored
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         hrdata <= 32'h00000000;
      else if (addrValid && !hwrite)
      begin
         unique case (haddr)
            ccl_pkg::ADDR_INPUT_CTRL:
               hrdata <= {24'h000000, ctrl.unitEnable, ctrl.inputShort, ctrl.inputSwap,
                          ctrl.positiveChannelSelect, ctrl.negativeChannelSelect};
            ccl_pkg::ADDR_OUT_REF1_CTRL:
               hrdata <= {24'h000000, 1'b0, ctrl.outputInvert, ctrl.filterSelect,
                          ctrl.refOneRoute, ctrl.autoSwitchEnable, ctrl.refOneSelect, 1'b0};
            ccl_pkg::ADDR_REF2_CTRL:
               hrdata <= {24'h000000, 3'h0, ctrl.refTwoRoute, ctrl.refTwoLevel};
            ccl_pkg::ADDR_IRQ_CTRL:
               hrdata <= {30'h00000000, globalIrqEnable, irqEnable};
            ccl_pkg::ADDR_STATUS:
               hrdata <= {30'h00000000, condOut, irqFlag};
            default:
               hrdata <= 32'h00000000;
         endcase
      end
   end

   // ***************************************************
   // control registers
   // ***************************************************
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl <= '0;
         irqEnable <= 1'b0;
         globalIrqEnable <= 1'b0;
      end
      else if (phWrite)
      begin
         unique case (phAddr)
            ccl_pkg::ADDR_INPUT_CTRL:
            begin
               ctrl.unitEnable <= hwdata[ccl_pkg::POS_UNIT_ENABLE];
               ctrl.inputShort <= hwdata[ccl_pkg::POS_INPUT_SHORT];
               ctrl.inputSwap <= hwdata[ccl_pkg::POS_INPUT_SWAP];
               ctrl.positiveChannelSelect <= hwdata[ccl_pkg::POS_POS_SEL +: 2];
               ctrl.negativeChannelSelect <= hwdata[ccl_pkg::POS_NEG_SEL +: 3];
            end
            ccl_pkg::ADDR_OUT_REF1_CTRL:
            begin
               ctrl.outputInvert <= hwdata[ccl_pkg::POS_OUTPUT_INVERT];
               ctrl.filterSelect <= hwdata[ccl_pkg::POS_FILTER_SELECT];
               ctrl.refOneRoute <= hwdata[ccl_pkg::POS_REF1_ROUTE];
               ctrl.autoSwitchEnable <= hwdata[ccl_pkg::POS_AUTO_SWITCH];
               ctrl.refOneSelect <= hwdata[ccl_pkg::POS_REF1_SEL +: 2];
            end
            ccl_pkg::ADDR_REF2_CTRL:
            begin
               ctrl.refTwoRoute <= hwdata[ccl_pkg::POS_REF2_ROUTE];
               ctrl.refTwoLevel <= hwdata[ccl_pkg::POS_REF2_LEVEL +: 4];
            end
            ccl_pkg::ADDR_IRQ_CTRL:
            begin
               irqEnable <= hwdata[ccl_pkg::POS_IRQ_ENABLE];
               globalIrqEnable <= hwdata[ccl_pkg::POS_GLOBAL_IRQ_ENABLE];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ***************************************************
   // output conditioning
   // ***************************************************
   ccl_glitch_filter u_filter
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .rawIn(cmpRaw),
      .filterSelect(ctrl.filterSelect),
      .syncOut(syncRaw),
      .filtOut(filtRaw)
   );

   // filter bypass is exact: with select low the filter stage is transparent
   assign condOut = ctrl.unitEnable & ((ctrl.filterSelect ? filtRaw : syncRaw)
                    ^ ctrl.outputInvert);
   assign condRise = condOut && !condPrev;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         condPrev <= 1'b0;
         comparatorOutput <= 1'b0;
      end
      else
      begin
         condPrev <= condOut;
         comparatorOutput <= condOut;
      end
   end

   // ***************************************************
   // interrupt flag
   // ***************************************************
   assign flagClear = phWrite && phAddr == ccl_pkg::ADDR_STATUS && hwdata[ccl_pkg::POS_IRQ_FLAG];

   // a rise in the clearing cycle wins, so no edge is lost
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         irqFlag <= 1'b0;
      else if (condRise)
         irqFlag <= 1'b1;
      else if (flagClear)
         irqFlag <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         cmpIrq <= 1'b0;
      else
         cmpIrq <= irqFlag && irqEnable && globalIrqEnable;
   end

   // ***************************************************
   // auto switch of reference one
   // ***************************************************
   assign autoActive = ctrl.autoSwitchEnable && ctrl.refOneSelect[1];

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         autoHalf <= 1'b1;
      else if (!autoActive)
         autoHalf <= 1'b1;
      else if (condOut && !condPrev)
         autoHalf <= 1'b0;
      else if (!condOut && condPrev)
         autoHalf <= 1'b1;
   end

   assign effRefOne = autoActive ? (autoHalf ? ccl_pkg::REF1_HALF : ccl_pkg::REF1_QUARTER)
                      : ctrl.refOneSelect;

   // ***************************************************
   // analog switch control
   // ***************************************************
   // code 0 maps to no channel; position 0 of the negative decode is unused
   always_comb
   begin
      next_posOn = '0;
      next_negOn = '0;
      if (ctrl.positiveChannelSelect != 2'h0)
         next_posOn = ccl_onehot(3'(ctrl.positiveChannelSelect - 2'h1));
      if (ctrl.negativeChannelSelect != 3'h0)
         next_negOn = ccl_onehot(ctrl.negativeChannelSelect);
   end

   // the channel, short and reference switches are held off while the unit is disabled; swap, routing and levels pass through
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         analogCtrl <= '0;
      else
      begin
         analogCtrl.unitEnable <= ctrl.unitEnable;
         analogCtrl.posChannelOn <= ctrl.unitEnable ? next_posOn : 8'h00;
         analogCtrl.negChannelOn <= ctrl.unitEnable ? next_negOn : 8'h00;
         analogCtrl.inputSwap <= ctrl.inputSwap;
         analogCtrl.inputShort <= ctrl.unitEnable && ctrl.inputShort;
         analogCtrl.refOneSelect <= effRefOne;
         analogCtrl.refOneOn <= ctrl.unitEnable && effRefOne != ccl_pkg::REF1_HIZ;
         analogCtrl.refOneToNeg <= ctrl.refOneRoute ^ ctrl.inputSwap;
         analogCtrl.refTwoLevel <= ctrl.refTwoLevel;
         // reference two needs the common-mode source up; see the hand-over
         analogCtrl.refTwoOn <= ctrl.unitEnable && ctrl.refTwoLevel != 4'h0
                                && commonModeOn;
         analogCtrl.refTwoToNeg <= ctrl.refTwoRoute ^ ctrl.inputSwap;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cmpIrq |-> $past(irqFlag && irqEnable && globalIrqEnable))
      else $error("interrupt request without flag and both enables");

   sequence s_rise;
      !condPrev ##0 condOut;
   endsequence

   a_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_rise |=> irqFlag)
      else $error("rising output did not set the flag");

   a_auto_quarter: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (s_rise ##0 (autoActive && $stable(autoActive))) |=> ##1
      (analogCtrl.refOneSelect == ccl_pkg::REF1_QUARTER || !$past(autoActive)))
      else $error("auto switch did not drop to quarter supply");

   a_auto_half: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (autoActive && condPrev && !condOut) |=> autoHalf || !autoActive)
      else $error("auto switch did not return to half supply");

   a_pos_hiz: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ctrl.positiveChannelSelect == 2'h0) |=> analogCtrl.posChannelOn == 8'h00
      || $past(ctrl.positiveChannelSelect) != 2'h0)
      else $error("positive input not high impedance");

   a_ref_hiz: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ctrl.refOneSelect == 2'h0 && ctrl.refTwoLevel == 4'h0 && !autoActive)[*2]
      |-> !analogCtrl.refOneOn && !analogCtrl.refTwoOn)
      else $error("reference outputs not high impedance");

   a_route_swap: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $stable(ctrl.refOneRoute) && $stable(ctrl.inputSwap) |=>
      analogCtrl.refOneToNeg == $past(ctrl.refOneRoute ^ ctrl.inputSwap))
      else $error("reference one routing wrong");

   a_unit_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !ctrl.unitEnable ##1 !ctrl.unitEnable |-> !comparatorOutput
      && analogCtrl.posChannelOn == 8'h00)
      else $error("unit active while disabled");

   a_bus_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
      hreadyout && !hresp)
      else $error("slave stalled or errored");

endmodule : ccl_comparator_control

// >>> rtl/ccl_glitch_filter.sv
// synchroniser and glitch filter for the raw comparator result
// assumes the raw result is asynchronous to clk_sys
`timescale 1ns/1ps
module ccl_glitch_filter
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rawIn,
   input wire logic filterSelect,
   output logic syncOut,
   output logic filtOut
);

   logic meta;
   logic [ccl_pkg::FILTER_CNT_W-1:0] stableCnt;

   // two-flop synchroniser; meta is read only by syncOut
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta <= 1'b0;
         syncOut <= 1'b0;
      end
      else
      begin
         meta <= rawIn;
         syncOut <= meta;
      end
   end

   // output follows only after the input has held for the full filter time
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stableCnt <= '0;
         filtOut <= 1'b0;
      end
      else if (!filterSelect || syncOut == filtOut)
      begin
         stableCnt <= '0;
         filtOut <= syncOut;
      end
      else if (stableCnt == ccl_pkg::FILTER_CNT_W'(ccl_pkg::FILTER_CYCLES - 1))
      begin
         stableCnt <= '0;
         filtOut <= syncOut;
      end
      else
      begin
         stableCnt <= stableCnt + 1'b1;
      end
   end

endmodule : ccl_glitch_filter

// >>> rtl/ccl_pkg.sv
// package for the comparator control logic: register map, field layout, timing
// assumes a single 25 MHz system clock and an AHB-Lite register port
package ccl_pkg;

   // ***************************************************
   // register map (byte addresses, one word each)
   // ***************************************************
   localparam logic [7:0] ADDR_INPUT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OUT_REF1_CTRL = 8'h04;
   localparam logic [7:0] ADDR_REF2_CTRL = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   localparam logic [7:0] RST_INPUT_CTRL = 8'h00;
   localparam logic [7:0] RST_OUT_REF1_CTRL = 8'h00;
   localparam logic [7:0] RST_REF2_CTRL = 8'h00;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int POS_UNIT_ENABLE = 7;
   localparam int POS_INPUT_SHORT = 6;
   localparam int POS_INPUT_SWAP = 5;
   localparam int POS_POS_SEL = 3;
   localparam int POS_NEG_SEL = 0;
   localparam int POS_OUTPUT_INVERT = 6;
   localparam int POS_FILTER_SELECT = 5;
   localparam int POS_REF1_ROUTE = 4;
   localparam int POS_AUTO_SWITCH = 3;
   localparam int POS_REF1_SEL = 1;
   localparam int POS_REF2_ROUTE = 4;
   localparam int POS_REF2_LEVEL = 0;
   localparam int POS_IRQ_ENABLE = 0;
   localparam int POS_GLOBAL_IRQ_ENABLE = 1;
   localparam int POS_IRQ_FLAG = 0;
   localparam int POS_CMP_OUT = 1;

   // ***************************************************
   // reference one codes
   // ***************************************************
   localparam logic [1:0] REF1_HIZ = 2'h0;
   localparam logic [1:0] REF1_TEMP = 2'h1;
   localparam logic [1:0] REF1_QUARTER = 2'h2;
   localparam logic [1:0] REF1_HALF = 2'h3;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_MHZ = 25;
   localparam int FILTER_TIME_NS = 2000;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int FILTER_CNT_W = $clog2(FILTER_CYCLES + 1);

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic unitEnable;
      logic inputShort;
      logic inputSwap;
      logic outputInvert;
      logic filterSelect;
      logic autoSwitchEnable;
      logic refOneRoute;
      logic refTwoRoute;
      logic [1:0] refOneSelect;
      logic [3:0] refTwoLevel;
      logic [1:0] positiveChannelSelect;
      logic [2:0] negativeChannelSelect;
   } ccl_ctrl_t;

   typedef struct packed {
      logic [7:0] posChannelOn;
      logic [7:0] negChannelOn;
      logic inputSwap;
      logic inputShort;
      logic [1:0] refOneSelect;
      logic refOneOn;
      logic refOneToNeg;
      logic [3:0] refTwoLevel;
      logic refTwoOn;
      logic refTwoToNeg;
      logic unitEnable;
   } ccl_analog_t;

endpackage : ccl_pkg
